/* hdl/sbs_sram_dev.sv */
// SRAM side: burst address generation, write pipeline and sleep control
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

// How it works
// - Advance high steps counter, uses its address
// - Advance low loads the external start address
// - Counter wraps to start on fifth clock
// - Order select low gives linear bursts
// - Order select high gives interleaved bursts
// - Linear: low bits plus one, modulo four
// - Interleaved: start bits XOR access index
// - Sleep request held low, pulled down
// - Sleep begins two cycles after request rises
// - Sleep keeps all internal state intact
// - Normal operation two cycles after release
// - Asleep: deselected, inputs ignored, outputs off
// - Sleep lasts exactly while request stays high
// - Sleep request is asynchronous, active high
// - Controller drains pending accesses before sleeping
// - Only deselects or reads during recovery
// - Mode pin picks flow-through, pulled high
// - Burst generator is a two-bit counter
// - Flow-through: write data one edge later
// - Hold high freezes address and burst state
module sbs_sram_dev (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Controller link
	sbs_link_if.dev link,
	// Read side of the array
	output logic mem_rd_o,
	output var sbs_pkg::sbs_addr_t mem_addr_o,
	output logic dq_oe_n_o,
	// Write side of the array
	output logic mem_we_o,
	output var sbs_pkg::sbs_addr_t mem_waddr_o,
	output var sbs_pkg::sbs_data_t mem_wdata_o,
	// Status
	output logic asleep_o,
	output logic recovering_o,
	output logic ft_mode_o
);
	import sbs_pkg::*;

	logic sleep_meta_reg;
	logic sleep_sync_reg;
	sbs_slp_state_t slp_reg;
	logic [`SBS_RECOV_W-1:0] recov_reg;
	logic asleep;
	logic recovering;
	logic run;
	logic load;
	logic load_sel;
	logic step;
	logic ft;
	logic acc_wr_now;
	logic acc_go;
	logic [`SBS_LOW_W-1:0] low_bits;
	logic [`SBS_ADDR_W-1:`SBS_LOW_W] upper_reg;
	logic burst_act_reg;
	logic burst_wr_reg;
	logic acc_vld_reg;
	logic acc_wr_reg;
	logic acc_strobe_reg;
	logic rd_now;
	logic rd_late_reg;
	logic wr_now;
	logic wr_late_reg;
	sbs_addr_t wr_late_addr_reg;
	logic ft_mode_reg;

	// ----------------------------------------
	// Sleep request synchroniser
	// ----------------------------------------
	// Two flops give both the crossing and the two-cycle entry delay
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_meta_reg <= 1'h0;
			sleep_sync_reg <= 1'h0;
		end else begin
			sleep_meta_reg <= link.sleep_request;
			sleep_sync_reg <= sleep_meta_reg;
		end
	end

	// ----------------------------------------
	// Sleep state machine
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			slp_reg <= SBS_SLP_AWAKE;
			recov_reg <= '0;
		end else begin
			unique case (slp_reg)
				SBS_SLP_AWAKE: begin
					if (sleep_sync_reg) begin
						slp_reg <= SBS_SLP_DOZE;
					end
				end
				SBS_SLP_DOZE: begin
					if (!sleep_sync_reg) begin
						slp_reg <= SBS_SLP_WAKE;
						recov_reg <= `SBS_RECOV_LOAD;
					end
				end
				SBS_SLP_WAKE: begin
					if (sleep_sync_reg) begin
						slp_reg <= SBS_SLP_DOZE;
					end else if (recov_reg == `SBS_RECOV_LAST) begin
						slp_reg <= SBS_SLP_AWAKE;
					end else begin
						recov_reg <= `SBS_RECOV_W'(recov_reg - `SBS_RECOV_LAST);
					end
				end
				default: begin
					slp_reg <= SBS_SLP_AWAKE;
				end
			endcase
		end
	end

	assign asleep = sleep_sync_reg;
	// The first cycle after release already counts toward recovery
	assign recovering = !sleep_sync_reg && (slp_reg != SBS_SLP_AWAKE);

	// ----------------------------------------
	// Cycle qualification
	// ----------------------------------------
	// Burst and access registers hold while asleep and the strobes drop, so state survives the sleep
	assign run = !asleep && !link.hold;
	assign load = run && !link.advance_load_n;
	assign load_sel = load && !link.select_n;
	// A continue after a deselect stays deselected
	assign step = run && link.advance_load_n && burst_act_reg;
	assign ft = !link.flow_through_select;
	assign acc_wr_now = load ? !link.write_n : burst_wr_reg;
	// A write during recovery is an abort: no strobe, no drive, no write
	assign acc_go = (load_sel || step) && !(acc_wr_now && recovering);

	// ----------------------------------------
	// Burst address
	// ----------------------------------------
	sbs_burst_ctr u_ctr (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.load_i(load_sel),
		.step_i(step),
		.order_i(sbs_order_t'(link.burst_order_select)),
		.start_i(link.addr[`SBS_LOW_W-1:0]),
		.bits_o(low_bits)
	);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			upper_reg <= '0;
		end else if (load_sel) begin
			upper_reg <= link.addr[`SBS_ADDR_W-1:`SBS_LOW_W];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			burst_act_reg <= 1'h0;
			burst_wr_reg <= 1'h0;
		end else if (load) begin
			burst_act_reg <= !link.select_n;
			burst_wr_reg <= load_sel && !link.write_n;
		end
	end

	assign mem_addr_o = {upper_reg, low_bits};

	// ----------------------------------------
	// Access register
	// ----------------------------------------
	// Held across wait states so a stalled access is not lost
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_vld_reg <= 1'h0;
			acc_wr_reg <= 1'h0;
		end else if (run) begin
			acc_vld_reg <= acc_go;
			acc_wr_reg <= acc_wr_now;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_strobe_reg <= 1'h0;
		end else begin
			acc_strobe_reg <= acc_go && !acc_wr_now;
		end
	end

	assign rd_now = acc_vld_reg && !acc_wr_reg;
	assign wr_now = acc_vld_reg && acc_wr_reg;
	assign mem_rd_o = acc_strobe_reg;

	// ----------------------------------------
	// Late write and read pipelines
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_late_reg <= 1'h0;
			wr_late_addr_reg <= '0;
			rd_late_reg <= 1'h0;
		end else if (run) begin
			wr_late_reg <= wr_now;
			wr_late_addr_reg <= mem_addr_o;
			rd_late_reg <= rd_now;
		end
	end

	// Flow-through takes data one edge after the address, pipelined two
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mem_we_o <= 1'h0;
			mem_waddr_o <= '0;
			mem_wdata_o <= '0;
		end else if (run) begin
			mem_we_o <= ft ? wr_now : wr_late_reg;
			mem_waddr_o <= ft ? mem_addr_o : wr_late_addr_reg;
			mem_wdata_o <= link.wdata;
		end else begin
			mem_we_o <= 1'h0;
		end
	end

	// Sleep overrides every drive request
	assign dq_oe_n_o = asleep || !(ft ? rd_now : rd_late_reg);

	// ----------------------------------------
	// Status
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ft_mode_reg <= 1'h0;
		end else begin
			ft_mode_reg <= ft;
		end
	end

	assign ft_mode_o = ft_mode_reg;
	assign asleep_o = sleep_sync_reg;
	assign recovering_o = recovering;
endmodule

`default_nettype wire

/* hdl/sbs_defs.svh */
// Shared constants of the burst counter and sleep control link
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SBS_ADDR_W 20
`define SBS_LOW_W 2
`define SBS_DATA_W 18

// ----------------------------------------
// Burst counter values
// ----------------------------------------
`define SBS_IDX_FIRST 2'h0
`define SBS_IDX_STEP 2'h1

// ----------------------------------------
// Sleep timing, in clock cycles
// ----------------------------------------
`define SBS_SLEEP_ENTRY_CYC 2
`define SBS_SLEEP_RECOV_CYC 2
`define SBS_RECOV_W 2
`define SBS_RECOV_LOAD (2'(`SBS_SLEEP_RECOV_CYC - 1))
`define SBS_RECOV_LAST 2'h1
`define SBS_GUARD_W 3
`define SBS_GUARD_LOAD (3'(`SBS_SLEEP_ENTRY_CYC + `SBS_SLEEP_RECOV_CYC))
`define SBS_GUARD_IDLE 3'h0

`endif

/* hdl/sbs_pkg.sv */
// Types shared by both ends of the burst and sleep link
`default_nettype none
`include "sbs_defs.svh"

package sbs_pkg;

	// ----------------------------------------
	// Data types
	// ----------------------------------------
	typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
	typedef logic [`SBS_DATA_W-1:0] sbs_data_t;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic {
		SBS_ORDER_LINEAR = 1'h0,
		SBS_ORDER_INTERLEAVED = 1'h1
	} sbs_order_t;

	typedef enum logic [1:0] {
		SBS_SLP_AWAKE = 2'h0,
		SBS_SLP_DOZE = 2'h1,
		SBS_SLP_WAKE = 2'h3
	} sbs_slp_state_t;

	typedef enum logic [1:0] {
		SBS_OP_DESEL = 2'h0,
		SBS_OP_READ = 2'h1,
		SBS_OP_CONT = 2'h3,
		SBS_OP_WRITE = 2'h2
	} sbs_op_t;

endpackage

`default_nettype wire

/* hdl/sbs_link_if.sv */
// Link between the memory controller and the SRAM control logic
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

interface sbs_link_if;
	// ----------------------------------------
	// Synchronous control and address
	// ----------------------------------------
	logic hold;
	logic advance_load_n;
	logic select_n;
	logic write_n;
	logic burst_order_select;
	logic [`SBS_ADDR_W-1:0] addr;
	logic [`SBS_DATA_W-1:0] wdata;

	// ----------------------------------------
	// Mode pins with internal pulls
	// ----------------------------------------
	logic sleep_drv;
	logic sleep_oe_n;
	logic ft_drv;
	logic ft_oe_n;
	logic sleep_request;
	logic flow_through_select;

	// Undriven sleep pin reads inactive
	assign sleep_request = sleep_oe_n ? 1'h0 : sleep_drv;
	// Undriven mode pin reads high, pipelined
	assign flow_through_select = ft_oe_n ? 1'h1 : ft_drv;

	modport host (
		output hold, advance_load_n, select_n, write_n,
		output burst_order_select, addr, wdata,
		output sleep_drv, sleep_oe_n, ft_drv, ft_oe_n
	);

	modport dev (
		input hold, advance_load_n, select_n, write_n,
		input burst_order_select, addr, wdata,
		input sleep_request, flow_through_select
	);
endinterface

`default_nettype wire

/* hdl/sbs_burst_ctr.sv */
// Two-bit burst address counter with linear and interleaved order
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

module sbs_burst_ctr (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Control
	input wire logic load_i,
	input wire logic step_i,
	input wire sbs_pkg::sbs_order_t order_i,
	input wire logic [`SBS_LOW_W-1:0] start_i,
	// Low address bits
	output logic [`SBS_LOW_W-1:0] bits_o
);
	import sbs_pkg::*;

	logic [`SBS_LOW_W-1:0] base_reg;
	logic [`SBS_LOW_W-1:0] idx_reg;
	logic [`SBS_LOW_W-1:0] idx_next;
	logic [`SBS_LOW_W-1:0] base_next;
	logic [`SBS_LOW_W-1:0] bits_next;

	// ----------------------------------------
	// Next address
	// ----------------------------------------
	// The index is only two bits wide, so the fourth step lands on the start
	assign idx_next = load_i ? `SBS_IDX_FIRST :
		`SBS_LOW_W'(idx_reg + `SBS_IDX_STEP);
	assign base_next = load_i ? start_i : base_reg;

	always_comb begin
		if (order_i == SBS_ORDER_INTERLEAVED) begin
			bits_next = base_next ^ idx_next;
		end else begin
			bits_next = `SBS_LOW_W'(base_next + idx_next);
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			base_reg <= '0;
		end else if (load_i) begin
			base_reg <= start_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idx_reg <= '0;
			bits_o <= '0;
		end else if (load_i || step_i) begin
			idx_reg <= idx_next;
			bits_o <= bits_next;
		end
	end
endmodule

`default_nettype wire

/* hdl/sbs_sram_host.sv */
// Controller side: drives bursts, write data and sleep onto the link
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

module sbs_sram_host (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Command port
	input wire logic cmd_valid_i,
	input wire sbs_pkg::sbs_op_t cmd_op_i,
	input wire sbs_pkg::sbs_addr_t cmd_addr_i,
	input wire sbs_pkg::sbs_data_t cmd_wdata_i,
	output logic cmd_ready_o,
	// Mode and power
	input wire logic hold_i,
	input wire logic sleep_i,
	input wire logic interleave_i,
	input wire logic flow_through_i,
	output logic sleeping_o,
	output logic guard_o,
	output logic busy_o,
	// Link
	sbs_link_if.host link
);
	import sbs_pkg::*;

	logic hold_reg;
	logic adv_reg;
	logic sel_n_reg;
	logic wr_n_reg;
	sbs_addr_t addr_reg;
	sbs_data_t dat_reg;
	logic dat_vld_reg;
	sbs_data_t pipe_reg;
	logic pipe_vld_reg;
	sbs_data_t wdata_reg;
	logic out_vld_reg;
	logic burst_wr_reg;
	logic sleep_reg;
	logic [`SBS_GUARD_W-1:0] guard_reg;
	logic ft_reg;
	logic order_reg;
	logic is_wr;
	logic pending;
	logic take;

	// ----------------------------------------
	// Acceptance
	// ----------------------------------------
	assign is_wr = (cmd_op_i == SBS_OP_WRITE) ||
		((cmd_op_i == SBS_OP_CONT) && burst_wr_reg);
	assign pending = adv_reg || !sel_n_reg || dat_vld_reg ||
		pipe_vld_reg || out_vld_reg;
	assign cmd_ready_o = !hold_i && !sleep_i && !sleep_reg &&
		!(is_wr && (guard_reg != `SBS_GUARD_IDLE));
	assign take = cmd_valid_i && cmd_ready_o;

	// ----------------------------------------
	// Command onto the link
	// ----------------------------------------
	// Link command stays put on a held edge, as the device ignores it
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_reg <= 1'h0;
			adv_reg <= 1'h0;
			sel_n_reg <= 1'h1;
			wr_n_reg <= 1'h1;
			addr_reg <= '0;
			dat_reg <= '0;
			dat_vld_reg <= 1'h0;
		end else begin
			hold_reg <= hold_i;
			if (!hold_i) begin
				adv_reg <= take && (cmd_op_i == SBS_OP_CONT);
				sel_n_reg <= !(take && (cmd_op_i != SBS_OP_DESEL));
				wr_n_reg <= !(take && (cmd_op_i == SBS_OP_WRITE));
				dat_vld_reg <= take && is_wr;
				if (take) begin
					addr_reg <= cmd_addr_i;
					dat_reg <= cmd_wdata_i;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			burst_wr_reg <= 1'h0;
		end else if (take && (cmd_op_i != SBS_OP_CONT)) begin
			burst_wr_reg <= cmd_op_i == SBS_OP_WRITE;
		end
	end

	// ----------------------------------------
	// Late write data
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pipe_reg <= '0;
			pipe_vld_reg <= 1'h0;
			wdata_reg <= '0;
			out_vld_reg <= 1'h0;
		end else if (!hold_reg) begin
			pipe_reg <= dat_reg;
			pipe_vld_reg <= dat_vld_reg;
			wdata_reg <= ft_reg ? dat_reg : pipe_reg;
			out_vld_reg <= ft_reg ? dat_vld_reg : pipe_vld_reg;
		end
	end

	// ----------------------------------------
	// Sleep and recovery guard
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_reg <= 1'h0;
		end else if (!sleep_reg) begin
			sleep_reg <= sleep_i && !pending;
		end else begin
			sleep_reg <= sleep_i;
		end
	end

	// Guard spans the device's synchroniser plus its recovery time
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			guard_reg <= `SBS_GUARD_IDLE;
		end else if (sleep_reg && !sleep_i) begin
			guard_reg <= `SBS_GUARD_LOAD;
		end else if (guard_reg != `SBS_GUARD_IDLE) begin
			guard_reg <= `SBS_GUARD_W'(guard_reg - `SBS_GUARD_W'(1));
		end
	end

	// Mode straps; changing them mid-burst is not supported
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ft_reg <= 1'h0;
			order_reg <= 1'h0;
		end else begin
			ft_reg <= flow_through_i;
			order_reg <= interleave_i;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.hold = hold_reg;
	assign link.advance_load_n = adv_reg;
	assign link.select_n = sel_n_reg;
	assign link.write_n = wr_n_reg;
	assign link.addr = addr_reg;
	assign link.wdata = wdata_reg;
	assign link.burst_order_select = order_reg;
	assign link.sleep_drv = sleep_reg;
	// Sleep pin released while awake; its pull-down keeps it inactive
	assign link.sleep_oe_n = !sleep_reg;
	assign link.ft_drv = !ft_reg;
	// Mode pin released when pipelined; its pull-up reads high
	assign link.ft_oe_n = !ft_reg;
	assign sleeping_o = sleep_reg;
	assign guard_o = guard_reg != `SBS_GUARD_IDLE;
	assign busy_o = pending;
endmodule

`default_nettype wire

/* dv/sbs_link_checker.sv */
// Assertions on the controller to SRAM link and the device outputs
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

module sbs_link_checker (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Link
	input wire logic hold,
	input wire logic advance_load_n,
	input wire logic select_n,
	input wire logic write_n,
	input wire logic burst_order_select,
	input wire logic [`SBS_ADDR_W-1:0] addr,
	input wire logic [`SBS_DATA_W-1:0] wdata,
	input wire logic sleep_request,
	input wire logic flow_through_select,
	// Device outputs
	input wire logic mem_rd_o,
	input wire sbs_pkg::sbs_addr_t mem_addr_o,
	input wire logic mem_we_o,
	input wire sbs_pkg::sbs_data_t mem_wdata_o,
	input wire logic dq_oe_n_o,
	input wire logic asleep_o,
	input wire logic recovering_o
);
	import sbs_pkg::*;
	// ----
	// Properties
	// ----
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	logic go;
	assign go = !hold && !asleep_o;
	property p_load_read;
		go && !advance_load_n && !select_n && write_n |=>
			mem_rd_o && mem_addr_o == $past(addr);
	endproperty
	a_load_read: assert property (p_load_read)
		else $error("read load address not used");
	property p_adv_upper;
		go && advance_load_n && mem_rd_o |=> mem_rd_o &&
			mem_addr_o[`SBS_ADDR_W-1:`SBS_LOW_W] ==
			$past(mem_addr_o[`SBS_ADDR_W-1:`SBS_LOW_W]);
	endproperty
	a_adv_upper: assert property (p_adv_upper)
		else $error("advance lost read or upper bits");
	property p_lin_step;
		go && advance_load_n && mem_rd_o && !burst_order_select |=>
			mem_addr_o[1:0] == $past(mem_addr_o[1:0]) + 2'h1;
	endproperty
	a_lin_step: assert property (p_lin_step)
		else $error("linear step wrong");
	property p_hold;
		hold && !asleep_o |=> !mem_rd_o && $stable(mem_addr_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("wait state not honoured");
	property p_entry;
		$rose(sleep_request) |-> !asleep_o ##1 !asleep_o ##1 asleep_o;
	endproperty
	a_entry: assert property (p_entry)
		else $error("sleep entry timing wrong");
	property p_exit;
		$fell(sleep_request) |-> asleep_o ##1 asleep_o ##1
			(!asleep_o && recovering_o) ##1 recovering_o ##1 !recovering_o;
	endproperty
	a_exit: assert property (p_exit)
		else $error("wake timing wrong");
	property p_quiet;
		asleep_o |-> dq_oe_n_o && !mem_rd_o && !mem_we_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("activity while asleep");
	property p_recov;
		recovering_o && !advance_load_n && !select_n |-> write_n;
	endproperty
	a_recov: assert property (p_recov)
		else $error("write issued during recovery");
	property p_ft_write;
		(go && !recovering_o && !advance_load_n && !select_n && !write_n
			&& !flow_through_select) ##1 !hold |=>
			mem_we_o && mem_wdata_o == $past(wdata);
	endproperty
	a_ft_write: assert property (p_ft_write)
		else $error("flow-through write late or wrong");
endmodule

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench joining controller and SRAM ends over the link
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"

module tb_top;
	import sbs_pkg::*;
	// ----
	// Stimulus, monitors and tasks
	// ----
	logic sys_clk_i = 1'h0;
	logic rstn_i = 1'h0;
	logic cmd_valid_i = 1'h0;
	sbs_op_t cmd_op_i = SBS_OP_DESEL;
	sbs_addr_t cmd_addr_i = 20'h00000;
	sbs_data_t cmd_wdata_i = 18'h00000;
	logic hold_i = 1'h0;
	logic sleep_i = 1'h0;
	logic interleave_i = 1'h0;
	logic flow_through_i = 1'h0;
	logic cmd_ready_o, sleeping_o, guard_o, busy_o;
	logic mem_rd_o, dq_oe_n_o, mem_we_o, asleep_o, recovering_o, ft_mode_o;
	sbs_addr_t mem_addr_o, mem_waddr_o;
	sbs_data_t mem_wdata_o;
	int n_fail = 0;
	int comparisons = 0;
	sbs_addr_t rq[$];
	logic [37:0] wq[$];
	logic saw_guard = 1'h0;

	always #4 sys_clk_i = ~sys_clk_i;

	sbs_link_if i_sbs_link_if();
	sbs_sram_host i_sbs_sram_host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i),
		.cmd_ready_o(cmd_ready_o), .hold_i(hold_i), .sleep_i(sleep_i),
		.interleave_i(interleave_i), .flow_through_i(flow_through_i),
		.sleeping_o(sleeping_o), .guard_o(guard_o), .busy_o(busy_o),
		.link(i_sbs_link_if.host));
	sbs_sram_dev i_sbs_sram_dev (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.link(i_sbs_link_if.dev), .mem_rd_o(mem_rd_o),
		.mem_addr_o(mem_addr_o), .dq_oe_n_o(dq_oe_n_o), .mem_we_o(mem_we_o),
		.mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
		.asleep_o(asleep_o), .recovering_o(recovering_o),
		.ft_mode_o(ft_mode_o));
	sbs_link_checker i_sbs_link_checker (.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i), .hold(i_sbs_link_if.hold),
		.advance_load_n(i_sbs_link_if.advance_load_n),
		.select_n(i_sbs_link_if.select_n), .write_n(i_sbs_link_if.write_n),
		.burst_order_select(i_sbs_link_if.burst_order_select),
		.addr(i_sbs_link_if.addr), .wdata(i_sbs_link_if.wdata),
		.sleep_request(i_sbs_link_if.sleep_request),
		.flow_through_select(i_sbs_link_if.flow_through_select),
		.mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o),
		.mem_wdata_o(mem_wdata_o), .dq_oe_n_o(dq_oe_n_o),
		.asleep_o(asleep_o), .recovering_o(recovering_o));

	// Queues record accesses so timing slack never hides a wrong address
	always @(posedge sys_clk_i) begin
		if (mem_rd_o === 1'h1)
			rq.push_back(mem_addr_o);
		if (mem_we_o === 1'h1)
			wq.push_back({mem_waddr_o, mem_wdata_o});
		if (guard_o === 1'h1)
			saw_guard <= 1'h1;
	end

	task automatic chk(input logic [37:0] got, input logic [37:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Valid stays up after the taking edge so back-to-back calls never
	// assign it twice in one step; idle drops it
	task automatic cmd(input sbs_op_t op, input sbs_addr_t a,
		input sbs_data_t d);
		int n;
		n = 0;
		cmd_valid_i <= 1'h1;
		cmd_op_i <= op;
		cmd_addr_i <= a;
		cmd_wdata_i <= d;
		do @(negedge sys_clk_i); while (cmd_ready_o !== 1'h1 && ++n < 60);
		@(posedge sys_clk_i);
	endtask

	task automatic idle(input int n);
		cmd_valid_i <= 1'h0;
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic tally_and_finish();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk_i);
		n_fail++;
		tally_and_finish();
	end

	// ----
	// Test sequence
	// ----
	initial begin
		sbs_addr_t a;
		logic [1:0] e;
		repeat (16) @(posedge sys_clk_i);
		rstn_i <= 1'h1;
		@(posedge sys_clk_i);
		for (int o = 0; o < 2; o++) begin
			interleave_i <= o[0];
			for (int s = 0; s < 4; s++) begin
				a = {18'h2D5A3, s[1:0]};
				rq.delete();
				cmd(SBS_OP_READ, a, 18'h00000);
				for (int n = 1; n < 5; n++) begin
					if (n == 3) begin
						hold_i <= 1'h1;
						repeat (3) @(posedge sys_clk_i);
						hold_i <= 1'h0;
					end
					cmd(SBS_OP_CONT, a, 18'h00000);
				end
				idle(6);
				chk(38'(rq.size()), 38'h5);
				for (int n = 0; n < 5; n++) begin
					e = o[0] ? (s[1:0] ^ n[1:0]) : (s[1:0] + n[1:0]);
					chk(38'(rq[n]), {18'h00000, a[19:2], e});
				end
			end
		end
		interleave_i <= 1'h0;
		for (int f = 0; f < 2; f++) begin
			flow_through_i <= ~f[0];
			idle(4);
			chk(38'(ft_mode_o), 38'(flow_through_i));
			wq.delete();
			a = 20'h5A3C2;
			cmd(SBS_OP_WRITE, a, 18'h1B2C4);
			cmd(SBS_OP_CONT, a, 18'h2C3D5);
			idle(8);
			chk(38'(wq.size()), 38'h2);
			chk(wq[0], {a, 18'h1B2C4});
			chk(wq[1], {20'h5A3C3, 18'h2C3D5});
		end
		// Sleep waits for the read on the link; the address must survive
		// the nap, and a write must wait out recovery
		wq.delete();
		cmd(SBS_OP_READ, 20'h3A5C6, 18'h00000);
		sleep_i <= 1'h1;
		cmd_valid_i <= 1'h0;
		@(negedge sys_clk_i);
		chk(38'(busy_o), 38'h1);
		@(negedge sys_clk_i);
		chk(38'(sleeping_o), 38'h0);
		for (int i = 0; i < 20 && asleep_o !== 1'h1; i++)
			@(negedge sys_clk_i);
		repeat (10) @(negedge sys_clk_i);
		chk(38'(asleep_o), 38'h1);
		chk(38'(sleeping_o), 38'h1);
		chk(38'(cmd_ready_o), 38'h0);
		chk(38'(dq_oe_n_o), 38'h1);
		chk(38'(mem_addr_o), 38'h3A5C6);
		@(posedge sys_clk_i);
		sleep_i <= 1'h0;
		cmd(SBS_OP_WRITE, 20'h0F0F1, 18'h3C3C3);
		idle(8);
		chk(38'(saw_guard), 38'h1);
		chk(38'(asleep_o), 38'h0);
		chk(38'(wq.size()), 38'h1);
		chk(wq[0], {20'h0F0F1, 18'h3C3C3});
		tally_and_finish();
	end
endmodule

`default_nettype wire
